//--- include/ps_pkg.sv
package ps_pkg;

   // address and word widths
   localparam int PC_W      = 12;
   localparam int INSTR_W   = 16;
   localparam int ROM_WORDS = 3072;
   localparam int PHASES    = 4;

   // return stack
   localparam int STACK_DEPTH = 6;
   localparam int LEVEL_W     = 3;

   // start-up wait, counted in system clock periods
   localparam int SST_TSYS       = 1024;
   localparam int CLK_PER_TSYS   = 1;
   localparam int SST_CYCLES     = SST_TSYS * CLK_PER_TSYS;

   // fixed program addresses
   localparam logic [11:0] RESET_VEC = 12'h000;
   localparam logic [11:0] EXT_VEC   = 12'h004;
   localparam logic [11:0] TMR_VEC   = 12'h008;

   // one-hot phase after reset
   localparam logic [3:0] PHASE_FIRST = 4'h1;

   // register indices; byte address is four times the index
   localparam logic [5:0] REG_PCL_IDX  = 6'h06;
   localparam logic [5:0] REG_CTRL_IDX = 6'h20;
   localparam logic [5:0] REG_STAT_IDX = 6'h21;

   // control register fields
   localparam int         CTRL_MASTER = 0;
   localparam int         CTRL_EXT_EN = 1;
   localparam int         CTRL_TMR_EN = 2;
   localparam int         CTRL_W      = 3;
   localparam logic [2:0] CTRL_RST    = 3'h0;

   // status register fields
   localparam int STAT_LEVEL_LO = 0;
   localparam int STAT_EXT_PEND = 3;
   localparam int STAT_TMR_PEND = 4;
   localparam int STAT_RUNNING  = 5;
   localparam int STAT_FULL     = 6;

   // instruction encodings seen by the sequencer
   localparam logic [3:0]  OP_CALL    = 4'h2;
   localparam logic [3:0]  OP_JMP     = 4'h3;
   localparam logic [15:0] INSTR_RET  = 16'h0003;
   localparam logic [15:0] INSTR_RETI = 16'h0004;

   // sequencer run states
   typedef enum logic [1:0] {PS_START, PS_RUN, PS_HALT} ps_state_t;

endpackage : ps_pkg

//--- hdl/ps_return_stack.sv
`timescale 1ns/1ps
// return address stack, index zero is the empty top after reset
module ps_return_stack #(
   parameter int DEPTH   = ps_pkg::STACK_DEPTH,
   parameter int WIDTH   = ps_pkg::PC_W,
   parameter int LEVEL_W = ps_pkg::LEVEL_W
) (
   // clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_rst_n,
   // stack operations
   input  wire logic               i_push,
   input  wire logic               i_pop,
   input  wire logic [WIDTH-1:0]   i_data,
   output logic      [WIDTH-1:0]   o_top,
   output logic                    o_full,
   output logic      [LEVEL_W-1:0] o_level
);

   logic [WIDTH-1:0]   mem_q [DEPTH];
   logic [LEVEL_W-1:0] return_stack_index_q;
   logic               do_push;
   logic               do_pop;
   logic [LEVEL_W-1:0] top_idx;

   // pushes on a full stack and pops on an empty one are dropped
   assign o_full  = (return_stack_index_q == LEVEL_W'(DEPTH));
   assign do_push = i_push & ~o_full;
   assign do_pop  = i_pop & (return_stack_index_q != '0) & ~i_push;
   assign top_idx = return_stack_index_q - LEVEL_W'(1);
   assign o_top   = mem_q[top_idx];
   assign o_level = return_stack_index_q;

   // stack index, cleared to the top on reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         return_stack_index_q <= '0; // [RL18]
      end else if (do_push) begin
         return_stack_index_q <= return_stack_index_q + LEVEL_W'(1);
      end else if (do_pop) begin
         return_stack_index_q <= top_idx;
      end
   end

   // storage, written at the current index on a push
   always_ff @(posedge i_clk) begin
      if (do_push) begin
         mem_q[return_stack_index_q] <= i_data; // [RL17]
      end
   end

endmodule : ps_return_stack

//--- hdl/ps_sequencer.sv
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - four non-overlapping phases from the system clock
// RL2 - one instruction cycle is four clocks
// RL3 - fetch next word while executing current
// RL4 - counter changes cost two cycles with dummy
// RL5 - program counter is twelve bits wide
// RL6 - counter advances by one after each fetch
// RL7 - true skip drops next word, resumes plus two
// RL8 - low byte register at 06H, page jump
// RL9 - jump, call, return load all twelve bits
// RL10 - reset starts execution at address 000H
// RL11 - enabled external edge vectors to 004H
// RL12 - select pin picks rising or falling edge
// RL13 - enabled timer overflow vectors to 008H
// RL14 - program memory holds 3072 sixteen-bit words
// RL15 - wait 1024 clocks after power-up or wake
// RL16 - six stack levels, no vector when full
// RL17 - call and interrupt push, return pops
// RL18 - reset sets stack index to the top
// RL19 - external request wins, timer stays pending
// RL20 - vectoring only at boundary, call timing
module ps_sequencer #(
   parameter int SST_CYCLES  = ps_pkg::SST_CYCLES,
   parameter int STACK_DEPTH = ps_pkg::STACK_DEPTH,
   parameter int ROM_WORDS   = ps_pkg::ROM_WORDS
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   // program memory
   output logic      [11:0] o_rom_addr,
   input  wire logic [15:0] i_rom_data,
   // execute unit
   output logic      [15:0] o_instr,
   output logic             o_instr_valid,
   output logic      [3:0]  o_phase,
   input  wire logic        i_skip_true,
   input  wire logic        i_halt,
   // events
   input  wire logic        i_ext_irq_pin,
   input  wire logic        i_irq_edge_select_pin,
   input  wire logic        i_timer_ovf,
   input  wire logic        i_wake,
   output logic             o_running,
   // register bus, Avalon-MM slave
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest
);

   localparam int CNT_W = $clog2(SST_CYCLES + 1);
   localparam int PC_W  = ps_pkg::PC_W;
   localparam int LV_W  = ps_pkg::LEVEL_W;

   // reset synchroniser
   logic rst_meta_q;
   logic rst_n;

   // sequencer state
   ps_pkg::ps_state_t state_q;
   ps_pkg::ps_state_t state_d;
   logic [CNT_W-1:0]  sst_cnt_q;
   logic [CNT_W-1:0]  sst_cnt_d;
   logic              run_q;
   logic [3:0]        phase_q;
   logic [3:0]        phase_d;

   // pipeline
   logic [PC_W-1:0]   instr_address_counter_q;
   logic [PC_W-1:0]   instr_address_counter_d;
   logic [PC_W-1:0]   exec_addr_q;
   logic [15:0]       instr_q;
   logic              valid_q;
   logic              valid_d;

   // interrupt requests and control
   logic              ext_prev_q;
   logic              ext_pend_q;
   logic              tmr_pend_q;
   logic [2:0]        ctrl_q;
   logic [2:0]        ctrl_d;

   // low byte write held until the instruction boundary
   logic              pcl_pend_q;
   logic [7:0]        pcl_data_q;

   // bus
   logic              wait_q;
   logic [31:0]       rdata_q;

   // reset release through two flip-flops
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // instruction decode of the word being executed
   wire [3:0] op_field = instr_q[15:12];
   wire       boundary = run_q & phase_q[3];
   wire       is_jmp   = valid_q & (op_field == ps_pkg::OP_JMP);
   wire       is_call  = valid_q & (op_field == ps_pkg::OP_CALL);
   wire       is_reti  = valid_q & (instr_q == ps_pkg::INSTR_RETI);
   wire       is_ret   = valid_q & ((instr_q == ps_pkg::INSTR_RET) |
                                    is_reti);
   wire       is_skip  = valid_q & i_skip_true;
   wire       is_halt  = valid_q & i_halt;

   // bus decode
   wire [5:0] bus_idx   = i_avs_address[7:2];
   wire       bus_req   = i_avs_read | i_avs_write;
   wire       bus_start = bus_req & wait_q;
   wire       wr_fire   = i_avs_write & ~wait_q & i_avs_byteenable[0];
   wire       wr_pcl    = wr_fire & (bus_idx == ps_pkg::REG_PCL_IDX);
   wire       wr_ctrl   = wr_fire & (bus_idx == ps_pkg::REG_CTRL_IDX);

   // instructions that move the counter themselves
   wire       ctl_move  = is_jmp | is_call | is_ret | is_skip;

   // short jump replaces the low byte, keeps the page bits; a bus write
   // that meets a moving instruction waits for the next boundary
   wire       pcl_go    = boundary & (pcl_pend_q | wr_pcl) & ~ctl_move;
   wire [7:0] pcl_byte  = wr_pcl ? i_avs_writedata[7:0] : pcl_data_q;

   // any instruction that moves the counter
   wire       xfer      = ctl_move | pcl_go;

   // return stack view
   wire [PC_W-1:0] stack_top;
   wire            stack_full;
   wire [LV_W-1:0] stack_level;

   // external edge, polarity chosen by the select pin
   wire ext_rise = i_ext_irq_pin & ~ext_prev_q;
   wire ext_fall = ~i_ext_irq_pin & ext_prev_q;
   wire ext_edge = i_irq_edge_select_pin ? ext_rise : ext_fall; // [RL12]

   // interrupt acceptance between instructions only
   wire irq_ok   = boundary & ~xfer & ~is_halt & ~stack_full &
                   ctrl_q[ps_pkg::CTRL_MASTER]; // [RL16] [RL20]
   wire take_ext = irq_ok & ext_pend_q &
                   ctrl_q[ps_pkg::CTRL_EXT_EN]; // [RL11]
   wire take_tmr = irq_ok & tmr_pend_q & ~take_ext &
                   ctrl_q[ps_pkg::CTRL_TMR_EN]; // [RL13] [RL19]
   wire take_irq = take_ext | take_tmr;

   // stack traffic; the pushed address is the word now being fetched
   wire do_push  = boundary & (is_call | take_irq); // [RL17]
   wire do_pop   = boundary & is_ret; // [RL17]

   // read data selection
   wire [31:0] stat_word = {25'h0000000, stack_full, run_q, tmr_pend_q,
                            ext_pend_q, stack_level};
   wire [31:0] rd_mux =
      (bus_idx == ps_pkg::REG_PCL_IDX)  ? {24'h000000, exec_addr_q[7:0]} :
      (bus_idx == ps_pkg::REG_CTRL_IDX) ? {29'h00000000, ctrl_q} :
      (bus_idx == ps_pkg::REG_STAT_IDX) ? stat_word : 32'h00000000;

   // next program counter
   always_comb begin
      instr_address_counter_d = instr_address_counter_q;
      if (boundary) begin
         if (take_ext) begin
            instr_address_counter_d = ps_pkg::EXT_VEC; // [RL11]
         end else if (take_tmr) begin
            instr_address_counter_d = ps_pkg::TMR_VEC; // [RL13]
         end else if (is_ret) begin
            instr_address_counter_d = stack_top; // [RL9]
         end else if (is_jmp | is_call) begin
            instr_address_counter_d = instr_q[PC_W-1:0]; // [RL9]
         end else if (pcl_go) begin
            instr_address_counter_d = {exec_addr_q[11:8], pcl_byte}; // [RL8]
         end else begin
            // a skip also just steps on: the dropped word gives plus two
            instr_address_counter_d = instr_address_counter_q +
                                      PC_W'(1); // [RL6] [RL7]
         end
      end
   end

   // a moved counter turns the prefetched word into a dummy cycle
   assign valid_d = boundary ? ~(xfer | take_irq) : valid_q; // [RL4] [RL7]

   // run state: start-up wait, running, halted
   always_comb begin
      state_d   = state_q;
      sst_cnt_d = sst_cnt_q;
      unique case (state_q)
         ps_pkg::PS_START: begin
            if (sst_cnt_q == CNT_W'(SST_CYCLES - 1)) begin
               state_d = ps_pkg::PS_RUN; // [RL15]
            end else begin
               sst_cnt_d = sst_cnt_q + CNT_W'(1);
            end
         end
         ps_pkg::PS_RUN: begin
            if (boundary & is_halt) begin
               state_d = ps_pkg::PS_HALT;
            end
         end
         ps_pkg::PS_HALT: begin
            if (i_wake) begin
               state_d   = ps_pkg::PS_START; // [RL15]
               sst_cnt_d = '0;
            end
         end
      endcase
   end

   // phases rotate only while running, one instruction per turn
   assign phase_d = (state_d != ps_pkg::PS_RUN) ? ps_pkg::PHASE_FIRST :
                    ~run_q ? ps_pkg::PHASE_FIRST :
                    {phase_q[2:0], phase_q[3]}; // [RL1] [RL2]

   // control register: ack clears master enable, return from interrupt re-enables, plain return does not
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = i_avs_writedata[2:0];
      end
      if (take_irq) begin
         ctrl_d[ps_pkg::CTRL_MASTER] = 1'b0;
      end else if (boundary & is_reti) begin
         ctrl_d[ps_pkg::CTRL_MASTER] = 1'b1;
      end
   end

   // state, counter and phase registers
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= ps_pkg::PS_START;
         sst_cnt_q <= '0;
         run_q     <= 1'b0;
         phase_q   <= ps_pkg::PHASE_FIRST;
      end else begin
         state_q   <= state_d;
         sst_cnt_q <= sst_cnt_d;
         run_q     <= (state_d == ps_pkg::PS_RUN);
         phase_q   <= phase_d;
      end
   end

   // fetch at each boundary while the previous word executes
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_address_counter_q <= ps_pkg::RESET_VEC; // [RL10] [RL5]
         exec_addr_q             <= ps_pkg::RESET_VEC;
         instr_q                 <= 16'h0000;
         valid_q                 <= 1'b0;
      end else begin
         instr_address_counter_q <= instr_address_counter_d;
         valid_q                 <= valid_d;
         if (boundary) begin
            instr_q     <= i_rom_data; // [RL3] [RL14]
            exec_addr_q <= instr_address_counter_q;
         end
      end
   end

   // request flags: a new event beats the clear of the same cycle
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_prev_q <= 1'b0;
         ext_pend_q <= 1'b0;
         tmr_pend_q <= 1'b0;
         ctrl_q     <= ps_pkg::CTRL_RST;
      end else begin
         ext_prev_q <= i_ext_irq_pin;
         ext_pend_q <= ext_edge | (ext_pend_q & ~take_ext);
         tmr_pend_q <= i_timer_ovf | (tmr_pend_q & ~take_tmr); // [RL19]
         ctrl_q     <= ctrl_d;
      end
   end

   // low byte write waits for the end of the current instruction
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pcl_pend_q <= 1'b0;
         pcl_data_q <= 8'h00;
      end else begin
         pcl_pend_q <= (pcl_pend_q | wr_pcl) & ~pcl_go; // [RL8]
         pcl_data_q <= pcl_byte;
      end
   end

   // bus slave: one wait cycle, then a single cycle with waitrequest low
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h00000000;
      end else begin
         wait_q <= ~bus_start;
         if (bus_start & i_avs_read) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // return address stack
   ps_return_stack #(
      .DEPTH   (STACK_DEPTH),
      .WIDTH   (PC_W),
      .LEVEL_W (LV_W)
   ) u_stack (
      .i_clk   (i_clk),
      .i_rst_n (rst_n),
      .i_push  (do_push),
      .i_pop   (do_pop),
      .i_data  (instr_address_counter_q),
      .o_top   (stack_top),
      .o_full  (stack_full),
      .o_level (stack_level)
   );

   // outputs, all straight from flip-flops
   assign o_rom_addr        = instr_address_counter_q;
   assign o_instr           = instr_q;
   assign o_instr_valid     = valid_q;
   assign o_phase           = phase_q;
   assign o_running         = run_q;
   assign o_avs_readdata    = rdata_q;
   assign o_avs_waitrequest = wait_q;

endmodule : ps_sequencer

//--- tb/ps_sequencer_sva.sv
`timescale 1ns/1ps
// port checker for the instruction sequencer
module ps_sequencer_chk #(
   parameter int SST_CYCLES = ps_pkg::SST_CYCLES
) (
   // clock and reset
   input wire logic        i_clk,
   input wire logic        i_reset_n,
   // pipeline
   input wire logic [11:0] o_rom_addr,
   input wire logic [15:0] o_instr,
   input wire logic        o_instr_valid,
   input wire logic [3:0]  o_phase,
   input wire logic        i_skip_true,
   input wire logic        o_running,
   // register bus
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic        o_avs_waitrequest
);
   logic [11:0] cnt_q;
   logic        ran_q;
   // boundary edge of a real instruction
   wire         bnd_w = o_running && o_phase[3] && o_instr_valid;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // idle clocks before the first run, and a first-run flag
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) cnt_q <= 12'h000;
      else if (!o_running) cnt_q <= cnt_q + 12'h001;
   end
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) ran_q <= 1'b0;
      else if (o_running) ran_q <= 1'b1;
   end
   AST_PHASE_ONE: assert property (o_running |-> $onehot(o_phase))
      else $error("phase not one-hot");
   AST_CYCLE_FOUR: assert property (o_running && o_phase == 4'h1 |=>
      o_phase == 4'h2 ##1 o_phase == 4'h4 ##1 o_phase == 4'h8)
      else $error("instruction cycle not four clocks");
   AST_ADDR_HOLD: assert property ($changed(o_rom_addr) |->
      $past(o_phase[3])) else $error("fetch address moved mid cycle");
   AST_JUMP: assert property (bnd_w && o_instr[15:12] == ps_pkg::OP_JMP
      |=> o_rom_addr == $past(o_instr[11:0]) && !o_instr_valid)
      else $error("jump target or dummy wrong");
   AST_CALL: assert property (bnd_w && o_instr[15:12] == ps_pkg::OP_CALL
      |=> o_rom_addr == $past(o_instr[11:0]) && !o_instr_valid)
      else $error("call target or dummy wrong");
   AST_SKIP: assert property (bnd_w && i_skip_true &&
      o_instr[15:13] != 3'h1 |=> !o_instr_valid)
      else $error("skipped word not dropped");
   AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write) &&
      o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer not one wait cycle");
   AST_START: assert property ($rose(o_running) && !ran_q |->
      cnt_q >= SST_CYCLES && cnt_q <= SST_CYCLES + 8 &&
      o_rom_addr == ps_pkg::RESET_VEC)
      else $error("start-up wait or start address wrong");
endmodule : ps_sequencer_chk

bind ps_sequencer ps_sequencer_chk #(.SST_CYCLES(SST_CYCLES)) chk_u (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .o_rom_addr(o_rom_addr),
   .o_instr(o_instr), .o_instr_valid(o_instr_valid), .o_phase(o_phase),
   .i_skip_true(i_skip_true), .o_running(o_running),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_waitrequest(o_avs_waitrequest));

//--- tb/ps_rom_model.sv
`timescale 1ns/1ps
// program memory and execute-unit stand-in
module ps_rom_model (
   // fetch side
   input  wire logic [11:0] i_addr,
   output logic      [15:0] o_data,
   // execute side
   input  wire logic [15:0] i_instr,
   input  wire logic        i_valid,
   output logic             o_skip,
   output logic             o_halt
);
   logic [15:0] word_w;
   // small test program, unused words hold a marker
   always_comb begin
      case (i_addr)
         12'h000: word_w = 16'h3010;
         12'h004: word_w = 16'h0004;
         12'h008: word_w = 16'h1008;
         12'h009: word_w = 16'h0004;
         12'h010: word_w = 16'h2020;
         12'h011: word_w = 16'h5000;
         12'h013: word_w = 16'h3140;
         12'h020: word_w = 16'h0003;
         12'h140: word_w = 16'h3140;
         12'h180: word_w = 16'h3180;
         default: word_w = 16'h7777;
      endcase
   end
   // no word past the 3072-word array: bus shows a moving pattern
   assign o_data = (i_addr < 12'hC00) ? word_w : ~{4'h0, i_addr};
   assign o_skip = i_valid && (i_instr === 16'h5000);
   assign o_halt = i_valid && (i_instr === 16'h6000);
endmodule : ps_rom_model

//--- tb/test_program_sequencer.sv
`timescale 1ns/1ps
// sequencer bench: program trace plus register bus
module test_program_sequencer;
   logic        i_clk, i_reset_n, i_ext_irq_pin, i_irq_edge_select_pin;
   logic        i_timer_ovf, i_avs_read, i_avs_write, o_avs_waitrequest;
   logic        o_instr_valid, o_running, skip_w, halt_w;
   logic [11:0] o_rom_addr;
   logic [15:0] i_rom_data, o_instr;
   logic [3:0]  o_phase;
   logic [7:0]  i_avs_address, rd_q;
   logic [31:0] i_avs_writedata, o_avs_readdata;
   logic [15:0] log_q[$];
   int          fails, cmp_count, n4, i4, i8;
   ps_sequencer #(.SST_CYCLES(8)) dut_u (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .o_rom_addr(o_rom_addr),
      .i_rom_data(i_rom_data), .o_instr(o_instr),
      .o_instr_valid(o_instr_valid), .o_phase(o_phase),
      .i_skip_true(skip_w), .i_halt(halt_w),
      .i_ext_irq_pin(i_ext_irq_pin),
      .i_irq_edge_select_pin(i_irq_edge_select_pin),
      .i_timer_ovf(i_timer_ovf), .i_wake(1'b0), .o_running(o_running),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest));
   ps_rom_model rom_u (.i_addr(o_rom_addr), .o_data(i_rom_data),
      .i_instr(o_instr), .i_valid(o_instr_valid), .o_skip(skip_w),
      .o_halt(halt_w));
   // clock, 4 ns period
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // record every real instruction once per cycle
   always @(posedge i_clk) begin
      if (o_running && o_phase[0] && o_instr_valid === 1'b1) log_q.push_back(o_instr);
   end
   task automatic chk(input string nm, input logic [15:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // one bus access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, d);
      int t;
      i_avs_read <= !wr;
      i_avs_write <= wr;
      i_avs_address <= a;
      i_avs_writedata <= {24'h000000, d};
      t = 0;
      @(posedge i_clk);
      while (o_avs_waitrequest !== 1'b0 && t < 50) begin
         @(posedge i_clk);
         t++;
      end
      if (t >= 50) begin
         fails++;
         end_of_test();
      end
      rd_q = o_avs_readdata[7:0];
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_clk);
   endtask : bus
   task automatic end_of_test();
      if (fails == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   task automatic count_words();
      n4 = 0;
      i4 = -1;
      i8 = -1;
      foreach (log_q[k]) begin
         if (log_q[k] === 16'h0004) n4++;
         if (log_q[k] === 16'h0004 && i4 < 0) i4 = k;
         if (log_q[k] === 16'h1008 && i8 < 0) i8 = k;
         if (log_q[k] === 16'h7777) chk("dropped word ran", log_q[k], 16'h0);
      end
   endtask : count_words
   initial begin
      #20000;
      fails++;
      end_of_test();
   end
   initial begin
      i_reset_n = 1'b0;
      {i_ext_irq_pin, i_timer_ovf, i_avs_read, i_avs_write} = 4'h0;
      i_irq_edge_select_pin = 1'b1;
      i_avs_address = 8'h00;
      i_avs_writedata = 32'h00000000;
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (300) @(posedge i_clk);
      chk("reset run", {15'h0, o_running}, 16'h0001);
      chk("jmp", log_q[0], 16'h3010);
      chk("call", log_q[1], 16'h2020);
      chk("ret", log_q[2], 16'h0003);
      chk("skip", log_q[3], 16'h5000);
      chk("after skip", log_q[4], 16'h3140);
      bus(1'b0, 8'h80, 8'h00);
      chk("ctrl reset", {8'h0, rd_q}, 16'h0000);
      bus(1'b0, 8'hF0, 8'h00);
      chk("unmapped", {8'h0, rd_q}, 16'h0000);
      bus(1'b0, 8'h18, 8'h00);
      chk("low byte", {12'h0, rd_q[7:4]}, 16'h0004);
      bus(1'b1, 8'h18, 8'h80);
      repeat (100) @(posedge i_clk);
      chk("page jump", log_q[$], 16'h3180);
      bus(1'b1, 8'h80, 8'h07);
      i_ext_irq_pin <= 1'b1;
      i_timer_ovf <= 1'b1;
      @(posedge i_clk);
      i_timer_ovf <= 1'b0;
      repeat (300) @(posedge i_clk);
      count_words();
      chk("vectors taken", n4[15:0], 16'h0002);
      chk("ext first", {15'h0, i4 < i8}, 16'h0001);
      i_irq_edge_select_pin <= 1'b0;
      i_ext_irq_pin <= 1'b0;
      repeat (200) @(posedge i_clk);
      i_ext_irq_pin <= 1'b1;
      repeat (200) @(posedge i_clk);
      count_words();
      chk("falling edge", n4[15:0], 16'h0003);
      chk("back home", log_q[$], 16'h3180);
      end_of_test();
   end
endmodule : test_program_sequencer
